// File: design/cpms_defines.svh
// constants of the chip power mode sequencer
// assumes inclusion by bare name, after nothing else
`ifndef CPMS_DEFINES_SVH
`define CPMS_DEFINES_SVH
`define CPMS_CLK_NS 100
`define CPMS_WAKE_RST_NS 200
`define CPMS_WAKE_RST_CYC \
  ((`CPMS_WAKE_RST_NS + `CPMS_CLK_NS - 1) / `CPMS_CLK_NS)
`define CPMS_STOP_NORMAL 3'h0
`define CPMS_STOP_LP 3'h1
`define CPMS_STOP_LL 3'h2
`define CPMS_STOP_VLL3 3'h3
`define CPMS_STOP_VLL1 3'h4
`endif

// File: design/cpms_pkg.sv
// types of the chip power mode sequencer
// assumes cpms_defines.svh holds the numbers
package cpms_pkg;
  typedef enum logic [3:0] {
    CPMS_RUN, CPMS_WAIT, CPMS_STOP, CPMS_LP_RUN, CPMS_LP_WAIT,
    CPMS_LP_STOP, CPMS_LL_STOP, CPMS_VLL_STOP3, CPMS_VLL_STOP1,
    CPMS_WAKE_RST
  } cpms_state_type;
endpackage : cpms_pkg

// File: design/cpms_sequencer.sv
// chip power mode sequencer: run, wait and stop modes and recovery
// assumes one 10 MHz clock; wake inputs arrive asynchronously
`timescale 1ns/1ps
`include "cpms_defines.svh"

module cpms_sequencer
  import cpms_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic wait_for_interrupt_instr_i,
  input wire logic sleep_deep_i,
  input wire logic [2:0] stop_sel_i,
  input wire logic low_power_run_req_i,
  input wire logic normal_run_req_i,
  input wire logic bypassed_external_clock_mode_i,
  input wire logic irq_pending_i,
  input wire logic wake_event_i,
  input wire logic timer_pwm_module_en_i,
  input wire logic timer_pwm_module_clk_src_en_i,
  input wire logic uart_en_i,
  input wire logic uart_clk_src_en_i,
  input wire logic wake_flag_clr_i,
  output logic [3:0] mode_o,
  output logic core_sleep_o,
  output logic core_sleep_deep_o,
  output logic periph_clk_en_o,
  output logic core_free_running_clock_o,
  output logic nested_irq_controller_en_o,
  output logic async_wake_irq_controller_en_o,
  output logic low_leakage_wake_unit_en_o,
  output logic regulator_low_power_o,
  output logic flash_slow_mode_o,
  output logic low_voltage_detect_en_o,
  output logic ext_clock_sel_o,
  output logic always_on_units_en_o,
  output logic timer_pwm_module_run_o,
  output logic uart_run_o,
  output logic sram_upper_pwr_o,
  output logic sram_lower_pwr_o,
  output logic regs_retained_o,
  output logic pin_hold_o,
  output logic wake_reset_o,
  output logic wake_flag_o,
  output logic wake_irq_o
);

  // ==========================================================
  // reset release and input synchronisers
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] wake_sync_r;
  logic [1:0] irq_sync_r;
  logic wake_s, irq_s;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // wake and irq come from always-on logic outside this clock
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_sync_r <= 2'h0;
      irq_sync_r <= 2'h0;
    end else if (clk_en_i) begin
      wake_sync_r <= {wake_sync_r[0], wake_event_i};
      irq_sync_r <= {irq_sync_r[0], irq_pending_i};
    end
  end
  assign wake_s = wake_sync_r[1];
  assign irq_s = irq_sync_r[1];

  // ==========================================================
  // mode state machine
  cpms_state_type state_r, state_nxt;
  logic [1:0] rst_cnt_r, rst_cnt_nxt;
  logic lp_r, lp_nxt;
  logic ext_r, ext_nxt;
  logic flag_r, flag_nxt;
  logic wirq_r, wirq_nxt;

  function automatic cpms_state_type stop_pick(input logic [2:0] sel,
                                               input logic lp);
    unique case (sel)
      `CPMS_STOP_LL: stop_pick = CPMS_LL_STOP;
      `CPMS_STOP_VLL3: stop_pick = CPMS_VLL_STOP3;
      `CPMS_STOP_VLL1: stop_pick = CPMS_VLL_STOP1;
      `CPMS_STOP_LP: stop_pick = CPMS_LP_STOP;
      default: stop_pick = lp ? CPMS_LP_STOP : CPMS_STOP;
    endcase
  endfunction : stop_pick

  always_comb begin
    state_nxt = state_r;
    rst_cnt_nxt = rst_cnt_r;
    lp_nxt = lp_r;
    ext_nxt = ext_r;
    flag_nxt = flag_r;
    wirq_nxt = 1'b0;
    // set wins over clear
    if (wake_flag_clr_i) begin
      flag_nxt = 1'b0;
    end
    unique case (state_r)
      CPMS_RUN, CPMS_LP_RUN: begin
        if (wait_for_interrupt_instr_i) begin
          if (sleep_deep_i) begin
            state_nxt = stop_pick(stop_sel_i, lp_r);
          end else begin
            state_nxt = lp_r ? CPMS_LP_WAIT : CPMS_WAIT;
          end
        end else if (!lp_r && low_power_run_req_i) begin
          lp_nxt = 1'b1;
          state_nxt = CPMS_LP_RUN;
          ext_nxt = bypassed_external_clock_mode_i;
        end else if (lp_r && normal_run_req_i) begin
          lp_nxt = 1'b0;
          ext_nxt = 1'b0;
          state_nxt = CPMS_RUN;
        end
      end
      CPMS_WAIT, CPMS_STOP: begin
        if (irq_s) begin
          state_nxt = CPMS_RUN;
        end
      end
      CPMS_LP_WAIT, CPMS_LP_STOP: begin
        if (irq_s) begin
          state_nxt = CPMS_LP_RUN;
        end
      end
      CPMS_LL_STOP: begin
        if (wake_s) begin
          flag_nxt = 1'b1;
          wirq_nxt = 1'b1;
          lp_nxt = 1'b0;
          ext_nxt = 1'b0;
          state_nxt = CPMS_RUN;
        end
      end
      CPMS_VLL_STOP3, CPMS_VLL_STOP1: begin
        if (wake_s) begin
          flag_nxt = 1'b1;
          rst_cnt_nxt = 2'(`CPMS_WAKE_RST_CYC - 1);
          state_nxt = CPMS_WAKE_RST;
        end
      end
      CPMS_WAKE_RST: begin
        if (rst_cnt_r == 2'h0) begin
          lp_nxt = 1'b0;
          ext_nxt = 1'b0;
          state_nxt = CPMS_RUN;
        end else begin
          rst_cnt_nxt = rst_cnt_r - 2'h1;
        end
      end
      default: state_nxt = CPMS_RUN;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CPMS_RUN;
      rst_cnt_r <= 2'h0;
      lp_r <= 1'b0;
      ext_r <= 1'b0;
      flag_r <= 1'b0;
      wirq_r <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      lp_r <= lp_nxt;
      ext_r <= ext_nxt;
      flag_r <= flag_nxt;
      wirq_r <= wirq_nxt;
    end
  end

  // ==========================================================
  // mode decode; outputs from state flops, except timer and uart run which also take their enable inputs
  logic is_lp, is_stop, is_vll, is_ll;
  assign is_lp = state_r inside {CPMS_LP_RUN, CPMS_LP_WAIT,
                                 CPMS_LP_STOP};
  assign is_vll = state_r inside {CPMS_VLL_STOP3, CPMS_VLL_STOP1};
  assign is_ll = is_vll || state_r == CPMS_LL_STOP;
  assign is_stop = is_ll || state_r inside {CPMS_STOP, CPMS_LP_STOP};

  assign mode_o = state_r;
  assign core_sleep_o = state_r inside {CPMS_WAIT, CPMS_LP_WAIT};
  assign core_sleep_deep_o = is_stop;
  assign periph_clk_en_o = !is_stop && state_r != CPMS_WAKE_RST;
  assign core_free_running_clock_o = !is_stop;
  assign nested_irq_controller_en_o = !is_stop;
  assign async_wake_irq_controller_en_o =
      state_r inside {CPMS_STOP, CPMS_LP_STOP};
  assign low_leakage_wake_unit_en_o = is_ll;
  assign regulator_low_power_o = is_lp;
  assign flash_slow_mode_o = is_lp;
  // low voltage detect only kept in normal run, wait, stop and wake reset
  assign low_voltage_detect_en_o = !is_lp && !is_ll;
  assign ext_clock_sel_o = ext_r;
  assign always_on_units_en_o = 1'b1;
  // host sets these clocks slow enough in bypassed internal mode
  assign timer_pwm_module_run_o = state_r == CPMS_LP_STOP ?
      (timer_pwm_module_en_i && timer_pwm_module_clk_src_en_i) :
      (!is_stop && timer_pwm_module_en_i);
  assign uart_run_o = state_r == CPMS_LP_STOP ?
      (uart_en_i && uart_clk_src_en_i) : (!is_stop && uart_en_i);
  assign sram_upper_pwr_o = 1'b1;
  assign sram_lower_pwr_o = 1'b1;
  assign regs_retained_o = !is_vll;
  assign pin_hold_o = is_stop || state_r == CPMS_WAKE_RST;
  assign wake_reset_o = state_r == CPMS_WAKE_RST;
  assign wake_flag_o = flag_r;
  // software must not mask this in the irq controller
  assign wake_irq_o = wirq_r;

  // ==========================================================
  // checks
  a_wait_entry: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && state_r == CPMS_RUN && wait_for_interrupt_instr_i &&
    !sleep_deep_i |=> state_r == CPMS_WAIT)
    else $error("wait not entered");
  a_stop_entry: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && state_r == CPMS_RUN && wait_for_interrupt_instr_i &&
    sleep_deep_i && stop_sel_i == `CPMS_STOP_NORMAL
    |=> state_r == CPMS_STOP)
    else $error("stop not entered");
  a_wait_clocks: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state_r == CPMS_WAIT |-> periph_clk_en_o && core_sleep_o
    && nested_irq_controller_en_o)
    else $error("normal wait clocks wrong");
  a_stop_gating: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state_r == CPMS_STOP |-> !periph_clk_en_o && low_voltage_detect_en_o
    && async_wake_irq_controller_en_o)
    else $error("normal stop gating wrong");
  a_lp_supply: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state_r == CPMS_LP_RUN |-> regulator_low_power_o
    && flash_slow_mode_o && !low_voltage_detect_en_o)
    else $error("low power run supply wrong");
  a_wait_exit: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && state_r == CPMS_LP_WAIT && irq_s
    |=> state_r == CPMS_LP_RUN)
    else $error("low power wait not left");
  sequence s_vll_wake;
    clk_en_i && is_vll && wake_s;
  endsequence
  a_wake_reset: assert property (@(posedge mclk_i) disable iff (!rst_n)
    s_vll_wake ##1 clk_en_i [*2] |=> state_r == CPMS_RUN
    && wake_flag_o)
    else $error("wake reset flow wrong");
  a_ll_exit: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && state_r == CPMS_LL_STOP && wake_s
    |=> state_r == CPMS_RUN && wake_irq_o)
    else $error("low leakage exit wrong");
  a_pins_held: assert property (@(posedge mclk_i) disable iff (!rst_n)
    is_stop |-> pin_hold_o)
    else $error("pins not held");
  a_timer_gate: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state_r == CPMS_LP_STOP && !timer_pwm_module_clk_src_en_i
    |-> !timer_pwm_module_run_o)
    else $error("timer runs without clock");
  a_ll_wake_unit: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state_r == CPMS_LL_STOP |-> low_leakage_wake_unit_en_o
    && !nested_irq_controller_en_o && !periph_clk_en_o)
    else $error("low leakage stop gating wrong");
  a_wake_irq_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && wake_irq_o |=> !wake_irq_o)
    else $error("wake irq longer than one cycle");
  a_flag_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && is_ll && wake_s && wake_flag_clr_i
    |=> wake_flag_o)
    else $error("wake flag clear beat its set");
  a_lp_wait_sleep: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state_r == CPMS_LP_WAIT |-> core_sleep_o && core_free_running_clock_o
    && regulator_low_power_o)
    else $error("low power wait outputs wrong");
  a_wait_refuse: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clk_en_i && state_r == CPMS_WAIT && wait_for_interrupt_instr_i
    && !irq_s |=> state_r == CPMS_WAIT)
    else $error("sleep request taken outside run");

endmodule : cpms_sequencer

// File: testbench/chip_power_mode_sequencer_tb.sv
// bench for the power mode sequencer: modes, exits, refusals
// assumes cpms_core_model drives the sleep instruction inputs
`timescale 1ns/1ps
module chip_power_mode_sequencer_tb;
  logic clk = 0, rst_n = 0, en = 1, lp_q = 0, nr_q = 0, ext = 0;
  logic irq = 0, wk = 0, clr = 0, sleep_req, deep;
  logic [3:0] tu = 4'h0, prev = 4'h0, mode_o;
  logic [2:0] sel;
  logic slp, dsl, pce, frc, nic, awk, lwu, reg_lo, fls, low_voltage_detect, ecs;
  logic aon, tmr, uart, su, sl, ret, wrst, wflg, ph, wirq;
  logic [3:0] q[$];
  int miscompares = 0, checked = 0, cyc = 0, seed = 72360;
  wire logic [10:0] sig = {mode_o, slp | dsl, dsl, pce, nic, reg_lo, low_voltage_detect,
    wrst};
  initial begin
    forever #50 clk = ~clk;
  end
  cpms_core_model core_u (.mclk_i(clk),
    .wait_for_interrupt_instr_o(sleep_req), .deep_o(deep), .sel_o(sel));
  cpms_sequencer dut_u (.mclk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
    .wait_for_interrupt_instr_i(sleep_req), .sleep_deep_i(deep),
    .stop_sel_i(sel), .low_power_run_req_i(lp_q),
    .normal_run_req_i(nr_q), .bypassed_external_clock_mode_i(ext),
    .irq_pending_i(irq), .wake_event_i(wk),
    .timer_pwm_module_en_i(tu[3]),
    .timer_pwm_module_clk_src_en_i(tu[2]), .uart_en_i(tu[1]),
    .uart_clk_src_en_i(tu[0]), .wake_flag_clr_i(clr), .mode_o(mode_o),
    .core_sleep_o(slp), .core_sleep_deep_o(dsl), .periph_clk_en_o(pce),
    .core_free_running_clock_o(frc), .nested_irq_controller_en_o(nic),
    .async_wake_irq_controller_en_o(awk),
    .low_leakage_wake_unit_en_o(lwu), .regulator_low_power_o(reg_lo),
    .flash_slow_mode_o(fls), .low_voltage_detect_en_o(low_voltage_detect),
    .ext_clock_sel_o(ecs), .always_on_units_en_o(aon),
    .timer_pwm_module_run_o(tmr),
    .uart_run_o(uart), .sram_upper_pwr_o(su), .sram_lower_pwr_o(sl),
    .regs_retained_o(ret), .pin_hold_o(ph), .wake_reset_o(wrst),
    .wake_flag_o(wflg), .wake_irq_o(wirq));
  // =========================================================
  // expected outputs per mode; regulator bit masked in ll and vll stops, only mode and wake reset bits checked in wake reset
  function automatic logic [10:0] ex(input logic [3:0] m);
    logic [6:0] b;
    case (m)
      4'h0: b = 7'b0011010;
      4'h1: b = 7'b1011010;
      4'h2: b = 7'b1100010;
      4'h3: b = 7'b0011100;
      4'h4: b = 7'b1011100;
      4'h5: b = 7'b1100100;
      4'h9: b = 7'b0000001;
      default: b = 7'b1100000;
    endcase
    return {m, b};
  endfunction : ex
  function automatic logic [10:0] mk(input logic [3:0] m);
    return (m == 4'h9) ? 11'h781 : (m > 4'h5) ? 11'h7fb : 11'h7ff;
  endfunction : mk
  task automatic check(input logic [10:0] g, input logic [10:0] e);
    checked++;
    if (g !== e) begin
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask : check
  task automatic summarize();
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // =========================================================
  // watcher: every mode change takes the oldest note
  always @(negedge clk) begin : watch
    logic [3:0] e;
    if (rst_n && mode_o !== prev) begin
      prev = mode_o;
      if (q.size() == 0) check(sig, 11'h7ff);
      else begin
        e = q.pop_front();
        check(sig & mk(e), ex(e) & mk(e));
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic wait_mode(input logic [3:0] m);
    for (int n = 0; n < 20 && mode_o !== m; n++) @(negedge clk);
  endtask : wait_mode
  task automatic enter(input logic d, input logic [2:0] s,
    input logic [3:0] m);
    q.push_back(m);
    core_u.issue(d, s);
    wait_mode(m);
  endtask : enter
  // lls and vlls leave on a wake event, the rest on an interrupt
  task automatic leave(input logic [3:0] m);
    logic [3:0] b;
    b = (m == 4'h4 || m == 4'h5) ? 4'h3 : 4'h0;
    if (m > 4'h6) q.push_back(4'h9);
    q.push_back(b);
    @(posedge clk);
    #1;
    if (m > 4'h5) wk = 1'b1;
    else irq = 1'b1;
    wait_mode(b);
    if (m == 4'h6) check(wirq, 1'b1);
    @(posedge clk);
    #1;
    {irq, wk} = 2'b00;
    repeat (4) @(posedge clk);
    #1;
  endtask : leave
  initial begin
    logic d;
    logic [2:0] s;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(sig, ex(4'h0));
    enter(1'b0, 3'h0, 4'h1);
    core_u.issue(1'b1, 3'h3);
    leave(4'h1);
    enter(1'b1, 3'h0, 4'h2);
    check({awk, ret}, 2'b11);
    leave(4'h2);
    en = 1'b0;
    core_u.issue(1'b0, 3'h0);
    en = 1'b1;
    {lp_q, ext} = 2'b11;
    q.push_back(4'h3);
    wait_mode(4'h3);
    @(posedge clk);
    #1 lp_q = 1'b0;
    check({ecs, fls}, 2'b11);
    enter(1'b0, 3'h0, 4'h4);
    check(frc, 1'b1);
    leave(4'h4);
    enter(1'b1, 3'h1, 4'h5);
    check(aon, 1'b1);
    for (int i = 0; i < 16; i++) begin
      #1 tu = i[3:0];
      #1 check({tmr, uart}, {&tu[3:2], &tu[1:0]});
    end
    leave(4'h5);
    nr_q = 1'b1;
    q.push_back(4'h0);
    wait_mode(4'h0);
    @(posedge clk);
    #1 nr_q = 1'b0;
    enter(1'b1, 3'h2, 4'h6);
    check(lwu, 1'b1);
    irq = 1'b1;
    repeat (6) @(posedge clk);
    leave(4'h6);
    clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    enter(1'b1, 3'h3, 4'h7);
    check({su, sl, ph, wflg}, 4'he);
    leave(4'h7);
    check(wflg, 1'b1);
    clr = 1'b1;
    #100 clr = 1'b0;
    #300 check(wflg, 1'b0);
    enter(1'b1, 3'h4, 4'h8);
    leave(4'h8);
    repeat (6) begin
      d = $random(seed);
      s = $random(seed);
      // undecoded variants fall back to normal stop from normal run
      s = (s == 3'h1) ? 3'h4 : s;
      enter(d, s, d ? ((s == 3'h0 || s > 3'h4) ? 4'h2 : s + 4'h4) :
        4'h1);
      leave(mode_o);
    end
    check(q.size(), 11'h0);
    summarize();
  end
endmodule : chip_power_mode_sequencer_tb

// File: testbench/cpms_core_model.sv
// core side model: issues the sleep instruction to the sequencer
// assumes the sequencer clock; levels stay as last configured
`timescale 1ns/1ps
module cpms_core_model (
  input wire logic mclk_i,
  output logic wait_for_interrupt_instr_o,
  output logic deep_o,
  output logic [2:0] sel_o
);
  initial begin
    wait_for_interrupt_instr_o = 1'b0;
    deep_o = 1'b0;
    sel_o = 3'h0;
  end
  // =========================================================
  // one-cycle pulse; depth and variant are held levels
  task automatic issue(input logic d, input logic [2:0] s);
    @(posedge mclk_i);
    #1;
    wait_for_interrupt_instr_o = 1'b1;
    deep_o = d;
    sel_o = s;
    @(posedge mclk_i);
    #1;
    wait_for_interrupt_instr_o = 1'b0;
  endtask : issue
endmodule : cpms_core_model
